// *** rtl/scs_consts.svh ***
// Constants for the system clock switch and clock interrupt block.
// Assumes inclusion by bare name from rtl/ files.
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_OFF_CFG 12'h004
`define SCS_OFF_IRQ 12'h008
`define SCS_OFF_CTL 12'h00c

`define SCS_CFG_SW_LSB 0
`define SCS_CFG_STS_LOW 3
`define SCS_CFG_PRES_LSB 4
`define SCS_CFG_STS_EXT_LSB 14
`define SCS_CFG_RESET 32'h0000_0000

`define SCS_IRQ_GUARD_CLR 23
`define SCS_IRQ_PAR_CLR 21
`define SCS_IRQ_RDY_CLR_LSB 16
`define SCS_IRQ_PAR_RST_EN 14
`define SCS_IRQ_PAR_IRQ_EN 13
`define SCS_IRQ_RDY_EN_LSB 8
`define SCS_IRQ_GUARD_FLAG 7
`define SCS_IRQ_PAR_FLAG 5
`define SCS_IRQ_RDY_FLAG_LSB 0
`define SCS_IRQ_RESET 32'h0000_0000

`define SCS_CTL_GUARD_EN 0

`define SCS_SRC_INT_FAST 3'h0
`define SCS_PRES_MAX 4'hf
`define SCS_DIV_MAX_LOG2 9

`endif

// *** rtl/scs_flag.sv ***
// One sticky flag: hardware set, write-one clear, set wins.
// Assumes set and clear are on mclk.
`timescale 1ns/1ps
`default_nettype none
module scs_flag
(
  // Clock
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Events
  input wire logic set_in,
  input wire logic clr_in,
  // State
  output logic flag_q
);
  always_ff @(posedge mclk)
  begin
    if (reset)
      flag_q <= 1'b0;
    else if (clk_en)
    begin
      if (set_in)
        flag_q <= 1'b1;
      else if (clr_in)
        flag_q <= 1'b0;
    end
  end

  set_wins_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && set_in) |=> flag_q) else $error("flag set lost");
endmodule
`default_nettype wire

// *** rtl/scs_pkg.sv ***
// Types shared by the clock switch block and its submodules.
// Assumes no surroundings.
package scs_pkg;
  // Source index order for the select and status fields; ready flag bits follow scs_ready_t
  typedef enum logic [2:0] {
    SCS_SRC_HSI_E = 3'h0,
    SCS_SRC_HSE_E = 3'h1,
    SCS_SRC_PLL_E = 3'h2,
    SCS_SRC_LSE_E = 3'h3,
    SCS_SRC_LSI_E = 3'h4
  } scs_src_t;

  typedef struct packed {
    logic pll;
    logic ext_fast;
    logic int_fast;
    logic ext_slow;
    logic int_slow;
  } scs_ready_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } scs_wreq_t;
endpackage

// *** rtl/scs_prescaler.sv ***
// Bus clock prescaler: enable pulse at system clock / divide code.
// Assumes the 4-bit prescaler code from the clock config register.
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.svh"
module scs_prescaler
  import scs_pkg::*;
(
  // Clock
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // Control
  input wire logic [3:0] bus_clock_prescaler,
  // Output
  output logic bus_clk_tick
);
  logic [8:0] cnt_q;
  logic [8:0] limit;

  // Divide code to terminal count; 1111 gives 512
  always_comb
  begin
    unique case (bus_clock_prescaler)
      4'h8: limit = 9'h001;
      4'h9: limit = 9'h003;
      4'ha: limit = 9'h007;
      4'hb: limit = 9'h00f;
      4'hc: limit = 9'h03f;
      4'hd: limit = 9'h07f;
      4'he: limit = 9'h0ff;
      `SCS_PRES_MAX: limit = 9'h1ff;
      default: limit = 9'h000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      cnt_q <= 9'h000;
    else if (clk_en)
      cnt_q <= (cnt_q >= limit) ? 9'h000 : cnt_q + 9'h001;
  end

  assign bus_clk_tick = (cnt_q >= limit);

  div512_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && bus_clock_prescaler == 4'hf && bus_clk_tick) |=>
    !bus_clk_tick) else $error("prescaler 512 tick repeated");
endmodule
`default_nettype wire

// *** rtl/scs_top.sv ***
// System clock switch, bus prescaler and clock interrupt register.
// Assumes AXI4-Lite master on mclk; event inputs synchronous to mclk
// except oscillator ready and failure levels, which are synchronised.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.svh"
module scs_top
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator status pins, asynchronous
  input wire scs_pkg::scs_ready_t osc_ready,
  input wire logic ext_fast_fail,
  // Same-domain events
  input wire logic stop_exit,
  input wire logic ram_parity_error,
  input wire logic [2:0] switch_done_src,
  input wire logic switch_done,
  // Outputs
  output logic [2:0] system_clock_source_select,
  output logic bus_clk_tick,
  output logic clock_irq,
  output logic ram_parity_reset_req
);
  import scs_pkg::*;

  logic [2:0] sw_q;
  logic [3:0] pres_q;
  logic [2:0] sts_q;
  logic [4:0] rdy_en_q;
  logic par_rst_en_q;
  logic par_irq_en_q;
  logic guard_en_q;
  logic [4:0] rdy_meta_q;
  logic [4:0] rdy_sync_q;
  logic fail_meta_q;
  logic fail_sync_q;
  logic [4:0] rdy_flag;
  logic guard_flag;
  logic par_flag;
  logic aw_hold_q;
  logic w_hold_q;
  scs_wreq_t wreq_q;
  logic wr_fire;
  logic [4:0] rdy_clr;
  logic [31:0] cfg_rd;
  logic [31:0] irq_rd;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;
  logic [31:0] wd;

  // Oscillator inputs cross into mclk
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rdy_meta_q <= 5'h00;
      rdy_sync_q <= 5'h00;
      fail_meta_q <= 1'b0;
      fail_sync_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rdy_meta_q <= osc_ready;
      rdy_sync_q <= rdy_meta_q;
      fail_meta_q <= ext_fast_fail;
      fail_sync_q <= fail_meta_q;
    end
  end

  // Write channel capture, address and data in either order
  assign s_axi_awready = clk_en && !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_hold_q && !s_axi_bvalid;
  assign wr_fire = aw_hold_q && w_hold_q;
  assign wd = wreq_q.data;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      wreq_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        wreq_q.addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_ok = (wreq_q.addr[11:2] == `SCS_OFF_CFG >> 2) ||
    (wreq_q.addr[11:2] == `SCS_OFF_IRQ >> 2) ||
    (wreq_q.addr[11:2] == `SCS_OFF_CTL >> 2);

  // Clock config: switch select and prescaler
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sw_q <= `SCS_SRC_INT_FAST;
      pres_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (wr_fire && wreq_q.addr[11:2] == `SCS_OFF_CFG >> 2 &&
        wreq_q.strb[0])
      begin
        sw_q <= wd[`SCS_CFG_SW_LSB +: 3];
        pres_q <= wd[`SCS_CFG_PRES_LSB +: 4];
      end
      // Force beats select only; prescaler write still lands
      if (stop_exit || (guard_en_q && fail_sync_q))
        sw_q <= `SCS_SRC_INT_FAST;
    end
  end

  // Hardware switch status follows completed switches
  always_ff @(posedge mclk)
  begin
    if (reset)
      sts_q <= `SCS_SRC_INT_FAST;
    else if (clk_en && switch_done)
      sts_q <= switch_done_src;
  end

  // Interrupt register enables and guard enable
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rdy_en_q <= 5'h00;
      par_rst_en_q <= 1'b0;
      par_irq_en_q <= 1'b0;
      guard_en_q <= 1'b0;
    end
    else if (clk_en && wr_fire)
    begin
      if (wreq_q.addr[11:2] == `SCS_OFF_IRQ >> 2 && wreq_q.strb[1])
      begin
        // Bits 12..8: pll, ext fast, int fast, ext slow, int slow
        rdy_en_q <=
          wd[`SCS_IRQ_RDY_EN_LSB +: 5];
        par_rst_en_q <= wd[`SCS_IRQ_PAR_RST_EN];
        par_irq_en_q <= wd[`SCS_IRQ_PAR_IRQ_EN];
      end
      if (wreq_q.addr[11:2] == `SCS_OFF_CTL >> 2 && wreq_q.strb[0])
        guard_en_q <= wd[`SCS_CTL_GUARD_EN];
    end
  end

  // Write-one clears, valid only in the write cycle
  logic irq_wr;
  assign irq_wr = wr_fire && wreq_q.addr[11:2] == `SCS_OFF_IRQ >> 2 &&
    wreq_q.strb[2];
  assign rdy_clr = irq_wr ? wd[`SCS_IRQ_RDY_CLR_LSB +: 5] : 5'h00;

  // Ready flags, one per source
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_rdy
      scs_flag u_flag (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .set_in(rdy_en_q[gi] && rdy_sync_q[gi]),
        .clr_in(rdy_clr[gi]),
        .flag_q(rdy_flag[gi])
      );
    end
  endgenerate

  scs_flag u_guard (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .set_in(fail_sync_q),
    .clr_in(irq_wr && wd[`SCS_IRQ_GUARD_CLR]),
    .flag_q(guard_flag)
  );

  scs_flag u_parity (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .set_in(ram_parity_error),
    .clr_in(irq_wr && wd[`SCS_IRQ_PAR_CLR]),
    .flag_q(par_flag)
  );

  scs_prescaler u_pres (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .bus_clock_prescaler(pres_q),
    .bus_clk_tick(bus_clk_tick)
  );

  assign system_clock_source_select = sw_q;
  assign clock_irq = (|rdy_flag) || guard_flag ||
    (par_flag && par_irq_en_q);
  assign ram_parity_reset_req = ram_parity_error && par_rst_en_q;

  // Read path; clear bits and reserved bits read zero
  always_comb
  begin
    cfg_rd = `SCS_CFG_RESET;
    cfg_rd[`SCS_CFG_SW_LSB +: 3] = sw_q;
    cfg_rd[`SCS_CFG_STS_LOW] = sts_q[0];
    cfg_rd[`SCS_CFG_STS_EXT_LSB +: 2] = sts_q[2:1];
    cfg_rd[`SCS_CFG_PRES_LSB +: 4] = pres_q;
    irq_rd = `SCS_IRQ_RESET;
    irq_rd[`SCS_IRQ_RDY_EN_LSB +: 5] = rdy_en_q;
    irq_rd[`SCS_IRQ_PAR_RST_EN] = par_rst_en_q;
    irq_rd[`SCS_IRQ_PAR_IRQ_EN] = par_irq_en_q;
    irq_rd[`SCS_IRQ_GUARD_FLAG] = guard_flag;
    irq_rd[`SCS_IRQ_PAR_FLAG] = par_flag;
    irq_rd[`SCS_IRQ_RDY_FLAG_LSB +: 5] = rdy_flag;
    rd_ok = 1'b1;
    if (s_axi_araddr[11:2] == `SCS_OFF_CFG >> 2)
      rd_mux = cfg_rd;
    else if (s_axi_araddr[11:2] == `SCS_OFF_IRQ >> 2)
      rd_mux = irq_rd;
    else if (s_axi_araddr[11:2] == `SCS_OFF_CTL >> 2)
      rd_mux = {31'h0, guard_en_q};
    else
    begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = clk_en && !s_axi_rvalid;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  stop_force_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && stop_exit) |=> system_clock_source_select == 3'h0)
    else $error("stop exit did not force fast osc");
  guard_force_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && guard_en_q && fail_sync_q) |=> sw_q == 3'h0)
    else $error("guard failure did not force fast osc");
  irq_level_a: assert property (@(posedge mclk) disable iff (reset)
    (guard_flag || (|rdy_flag)) |-> clock_irq)
    else $error("interrupt missing with flag set");
  par_irq_a: assert property (@(posedge mclk) disable iff (reset)
    (par_flag && !par_irq_en_q && !guard_flag && rdy_flag == 5'h00)
    |-> !clock_irq) else $error("parity irq not gated");
  par_reset_a: assert property (@(posedge mclk) disable iff (reset)
    ram_parity_reset_req |-> (par_rst_en_q && ram_parity_error))
    else $error("parity reset without enable");
  guard_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && irq_wr && wd[23] && !fail_sync_q) |=> !guard_flag)
    else $error("guard flag not cleared");
  par_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && irq_wr && wd[21] && !ram_parity_error) |=> !par_flag)
    else $error("parity flag not cleared");
  rdy_set_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && rdy_en_q[4] && rdy_sync_q[4]) |=> rdy_flag[4])
    else $error("pll lock flag not set");
  guard_set_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && fail_sync_q) |=> guard_flag)
    else $error("guard flag not set");
  wr_resp_a: assert property (@(posedge mclk) disable iff (reset)
    (clk_en && wr_fire) |=> s_axi_bvalid)
    else $error("write response missing");

  cov_switch_c: cover property (@(posedge mclk) disable iff (reset)
    wr_fire && wreq_q.addr[11:2] == 10'h001);
  cov_stop_c: cover property (@(posedge mclk) disable iff (reset)
    stop_exit && sw_q != 3'h0);
  cov_irq_c: cover property (@(posedge mclk) disable iff (reset)
    clock_irq ##1 !clock_irq);
  cov_par_c: cover property (@(posedge mclk) disable iff (reset)
    ram_parity_reset_req);
endmodule
`default_nettype wire

// *** verification/system_clock_switch_and_clock_irq_tb.sv ***
// Testbench for the clock switch and clock interrupt block.
// Assumes scs_top with AXI4-Lite registers at 0x004, 0x008 and 0x00c.
`timescale 1ns/1ps
`default_nettype none
module system_clock_switch_and_clock_irq_tb;
  import scs_pkg::*;
  logic mclk = 0;
  logic reset = 1;
  logic [11:0] awa = 12'h000;
  logic [11:0] ara = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wr_rdy, bv, arr, rv, tick, irq, prst;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, v;
  scs_ready_t ordy = '0;
  logic fail = 0, stx = 0, perr = 0, sdone = 0, ce = 1;
  logic [2:0] ssrc = 3'h0;
  logic [2:0] sel;
  int bad_count = 0;
  int total_checks = 0;
  int i;

  always #2.5 mclk = ~mclk;

  scs_top i_dut (
    .mclk(mclk), .reset(reset), .clk_en(ce),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .osc_ready(ordy),
    .ext_fast_fail(fail), .stop_exit(stx), .ram_parity_error(perr),
    .switch_done_src(ssrc), .switch_done(sdone),
    .system_clock_source_select(sel), .bus_clk_tick(tick),
    .clock_irq(irq), .ram_parity_reset_req(prst)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang();
    bad_count++;
    $display("[ERR] handshake expected 1 seen 0");
    print_verdict();
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 0;
    @(posedge mclk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1;
    wv <= 1;
    br <= 1;
    while (!tb && n < 50)
    begin
      @(negedge mclk);
      ta = awv & awr;
      tw = wv & wr_rdy;
      tb = bv & br;
      r = bresp;
      @(posedge mclk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) br <= 0;
      n++;
    end
    if (!tb) hang();
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    logic ta, tr;
    n = 0;
    tr = 0;
    @(posedge mclk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    while (!tr && n < 50)
    begin
      @(negedge mclk);
      ta = arv & arr;
      tr = rv & rr;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arv <= 0;
      if (tr) rr <= 0;
      n++;
    end
    if (!tr) hang();
  endtask

  task automatic rchk(input string nm, input logic [11:0] a,
    input logic [31:0] m, input logic [31:0] e);
    rd(a, v, rs);
    chk(nm, e, v & m);
  endtask

  task automatic ichk(input string nm, input logic e);
    @(negedge mclk);
    chk(nm, {31'h0, e}, {31'h0, irq});
  endtask

  // Measures the second tick interval after a prescaler write
  task automatic period(input logic [3:0] code, input int e);
    int n;
    n = 0;
    wr(12'h004, {24'h0, code, 4'h0}, 4'h1, rs);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(negedge mclk);
        n++;
      end while (tick !== 1'b1 && n < 1100);
      if (n >= 1100) hang();
    end
    chk("tick period", e, n);
  endtask

  initial
  begin
    step(2);
    reset <= 0;
    rchk("cfg reset", 12'h004, 32'hffff_ffff, 32'h0);
    rchk("irq reset", 12'h008, 32'hffff_ffff, 32'h0);
    chk("select reset", 32'h0, {29'h0, sel});
    wr(12'h040, 32'h1, 4'hf, rs);
    chk("unmapped bresp", 32'h2, {30'h0, rs});
    rd(12'h040, v, rs);
    chk("unmapped rresp", 32'h2, {30'h0, rs});
    chk("unmapped rdata", 32'h0, v);
    $display("test reset done");
    for (i = 0; i < 5; i++)
    begin
      wr(12'h004, 32'(i), 4'h1, rs);
      chk("select out", 32'(i), {29'h0, sel});
      rchk("select rd", 12'h004, 32'h7, 32'(i));
      @(posedge mclk);
      ssrc <= 3'(i);
      sdone <= 1;
      @(posedge mclk);
      sdone <= 0;
      rd(12'h004, v, rs);
      chk("status", 32'(i), {29'h0, v[15:14], v[3]});
    end
    // Status bits ignore software writes
    wr(12'h004, 32'h0000_c008, 4'h3, rs);
    rd(12'h004, v, rs);
    chk("status ro", 32'h4, {29'h0, v[15:14], v[3]});
    $display("test select done");
    wr(12'h004, 32'h2, 4'h1, rs);
    // Stop exit while frozen must not act
    @(posedge mclk);
    ce <= 0;
    stx <= 1;
    @(posedge mclk);
    stx <= 0;
    ce <= 1;
    step(1);
    chk("frozen select", 32'h2, {29'h0, sel});
    @(posedge mclk);
    stx <= 1;
    @(posedge mclk);
    stx <= 0;
    step(1);
    chk("stop select", 32'h0, {29'h0, sel});
    $display("test stop done");
    // Guard enabled, then an ext fast failure forces the select and sets the guard flag
    wr(12'h00c, 32'h1, 4'h1, rs);
    wr(12'h004, 32'h1, 4'h1, rs);
    @(posedge mclk);
    fail <= 1;
    step(6);
    fail <= 0;
    step(4);
    chk("guard select", 32'h0, {29'h0, sel});
    rchk("guard flag", 12'h008, 32'h80, 32'h80);
    ichk("guard irq", 1);
    wr(12'h008, 32'h0, 4'h4, rs);
    rchk("guard zero wr", 12'h008, 32'h80, 32'h80);
    wr(12'h008, 32'h0080_0000, 4'h4, rs);
    rchk("guard clear", 12'h008, 32'h00ff_0080, 32'h0);
    ichk("guard irq off", 0);
    wr(12'h00c, 32'h0, 4'h1, rs);
    $display("test guard done");
    for (i = 0; i < 5; i++)
    begin
      wr(12'h008, 32'(1 << (8 + i)), 4'h2, rs);
      rchk("enable rd", 12'h008, 32'h1f00, 32'(1 << (8 + i)));
      @(posedge mclk);
      ordy <= 5'h1f;
      step(6);
      ordy <= 5'h0;
      step(4);
      rchk("ready flags", 12'h008, 32'h1f, 32'(1 << i));
      ichk("ready irq", 1);
      wr(12'h008, 32'(1 << (16 + i)), 4'h4, rs);
      rchk("ready clear", 12'h008, 32'h00ff_001f, 32'h0);
      ichk("ready irq off", 0);
    end
    $display("test ready done");
    wr(12'h008, 32'h6000, 4'h2, rs);
    @(posedge mclk);
    perr <= 1;
    @(negedge mclk);
    chk("parity reset", 32'h1, {31'h0, prst});
    @(posedge mclk);
    perr <= 0;
    step(2);
    rchk("parity flag", 12'h008, 32'h20, 32'h20);
    ichk("parity irq", 1);
    wr(12'h008, 32'h0020_0000, 4'h4, rs);
    rchk("parity clear", 12'h008, 32'h20, 32'h0);
    wr(12'h008, 32'h0, 4'h2, rs);
    @(posedge mclk);
    perr <= 1;
    @(negedge mclk);
    chk("parity no reset", 32'h0, {31'h0, prst});
    @(posedge mclk);
    perr <= 0;
    step(2);
    ichk("parity masked", 0);
    rchk("parity kept", 12'h008, 32'h20, 32'h20);
    // Mid-run reset clears the sticky flag
    @(posedge mclk);
    reset <= 1;
    step(2);
    reset <= 0;
    rchk("irq after reset", 12'h008, 32'hffff_ffff, 32'h0);
    ichk("irq after reset", 0);
    $display("test parity done");
    period(4'hf, 512);
    period(4'h8, 2);
    period(4'h0, 1);
    $display("test prescaler done");
    print_verdict();
  end
endmodule
`default_nettype wire
